// [pkg/pdp_consts.vh]
// Constants for the dead-time and pseudo-random PWM channel.
// Assumes inclusion by bare name from the channel design file.
`ifndef PDP_CONSTS_VH
`define PDP_CONSTS_VH
// Register byte offsets.
`define PDP_OFS_ENABLE   8'h00
`define PDP_OFS_CTRL     8'h04
`define PDP_OFS_SWEVT    8'h08
`define PDP_OFS_STATUS   8'h0C
`define PDP_OFS_COUNTER  8'h10
`define PDP_OFS_CMP      8'h14
`define PDP_OFS_CMPBUF   8'h18
`define PDP_OFS_PER      8'h1C
`define PDP_OFS_PERBUF   8'h20
`define PDP_OFS_TRSEL    8'h24
`define PDP_OFS_EDGE     8'h28
`define PDP_OFS_ACTION   8'h2C
// Control register field positions.
`define PDP_CB_CMPSWAP   0
`define PDP_CB_PERSWAP   1
`define PDP_CB_ONESHOT   2
`define PDP_CB_SYNCKILL  3
`define PDP_CB_STOPKILL  4
`define PDP_CB_IRQTC     5
`define PDP_CB_IRQCC     6
`define PDP_CB_GEN_LO    8
`define PDP_CB_GEN_HI    15
`define PDP_CB_UD_LO     16
`define PDP_CB_UD_HI     17
`define PDP_CB_MODE_LO   24
`define PDP_CB_MODE_HI   26
// Mode codes.
`define PDP_MODE_PWM     3'h4
`define PDP_MODE_DT      3'h5
`define PDP_MODE_PRNG    3'h6
// Event bit positions.
`define PDP_EV_RELOAD    0
`define PDP_EV_START     1
`define PDP_EV_KILL      2
`define PDP_EV_SWITCH    3
// Edge select codes.
`define PDP_EDGE_RISE    2'h0
`define PDP_EDGE_FALL    2'h1
`define PDP_EDGE_BOTH    2'h2
`define PDP_EDGE_PASS    2'h3
// Output action codes.
`define PDP_ACT_SET      2'h0
`define PDP_ACT_CLR      2'h1
`define PDP_ACT_INV      2'h2
// Reset values.
`define PDP_RST_CTRL     32'h0400_0000
`define PDP_RST_PER      16'hFFFF
`define PDP_RST_ACTION   6'h3F
`endif

// [logic/pdp_channel.v]
// One PWM counter channel with dead-time and pseudo-random modes.
// Assumes a synchronous register port and synchronous trigger inputs.
//
// Overview of operation
// - Rising line: zero both, count, raise true.
// - Falling line: zero both, count, raise inverse.
// - Zero dead band: true output follows line.
// - Dead band covering a pulse removes it.
// - Dead-time mode uses field as length, unprescaled.
// - Mode 101 dead-time, 110 pseudo-random.
// - Dead-time keeps alignments, kills and swaps.
// - Counter waits for a start event.
// - Pseudo-random counter steps sixteen-bit LFSR.
// - Line high while low bits below compare.
// - Reload acts as start; pseudo-random mode keeps counter.
// - Pseudo-random terminal count when counter equals period.
// - Pending switch swaps pairs at terminal count.
// - Single run stops counter at terminal count.
// - Pseudo-random mode gives no wrap events.
// - Compare match only while running and equal.
// - Switch edge-detected, pending until terminal count.
// - Kill may stop pseudo-random counter too.
// - Interrupt request on terminal count or match.
// - Stop-on-kill stops counter, else only blocks.
// - Sync kill lasts until terminal count.
// - Dead band up to 255 clocks.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`include "pdp_consts.vh"
`timescale 1ns/100ps

module pdp_channel #(
    parameter DT_W = 8                     // Dead-band counter width.
) (
    input  wire        ref_clk,            // Counter clock, 200 MHz.
    input  wire        sys_rst,            // Synchronous reset.
    input  wire [7:0]  regAddr,            // Register byte address.
    input  wire [31:0] regWdata,           // Register write data.
    input  wire        regWr,              // Write strobe.
    input  wire        regRd,              // Read strobe.
    output reg  [31:0] regRdata,           // Read data, next cycle.
    input  wire        reloadIn,           // Reload trigger line.
    input  wire        startIn,            // Start trigger line.
    input  wire        killIn,             // Kill trigger line.
    input  wire        switchIn,           // Switch trigger line.
    output reg         lineOut,            // PWM line.
    output reg         lineOutInv,         // Complementary PWM line.
    output reg         delayedOutputTrue,  // Dead-time true output.
    output reg         delayedOutputInverse, // Dead-time inverse output.
    output reg         terminalCount,      // Terminal count pulse.
    output reg         compareMatch,       // Compare match pulse.
    output reg         irqReq              // Interrupt request pulse.
);

    // ==========================================================
    // Functions
    // ==========================================================

    // Detects an event on a trigger line from its edge setting.
    function evtDet;
        input [1:0] sel;
        input       cur;
        input       prv;
        begin
            case (sel)
                `PDP_EDGE_RISE: evtDet = cur & ~prv;
                `PDP_EDGE_FALL: evtDet = ~cur & prv;
                `PDP_EDGE_BOTH: evtDet = cur ^ prv;
                default:        evtDet = cur;
            endcase
        end
    endfunction

    // Applies an output action code to the current line level.
    function actApply;
        input [1:0] act;
        input       lvl;
        begin
            case (act)
                `PDP_ACT_SET: actApply = 1'b1;
                `PDP_ACT_CLR: actApply = 1'b0;
                `PDP_ACT_INV: actApply = ~lvl;
                default:      actApply = lvl;
            endcase
        end
    endfunction

    // ==========================================================
    // Registers and state
    // ==========================================================

    reg         enable_r;          // Channel enable.
    reg  [31:0] ctrl_r;            // Channel control register.
    reg  [15:0] counter_r;         // Counter or LFSR state.
    reg  [15:0] cmp_r;             // Compare value.
    reg  [15:0] cmpBuf_r;          // Compare shadow.
    reg  [15:0] per_r;             // Period value.
    reg  [15:0] perBuf_r;          // Period shadow.
    reg  [3:0]  trSel_r;           // Hardware trigger enables.
    reg  [7:0]  edge_r;            // Edge select, two bits per event.
    reg  [5:0]  action_r;          // Output actions: un, ov, cc.
    reg  [3:0]  trPrev_r;          // Previous trigger levels.
    reg         running_r;         // Counter is running.
    reg         downDir_r;         // Up/down counting direction.
    reg         swPend_r;          // Switch pending.
    reg         killLatch_r;       // Synchronous kill held.
    reg         line_r;            // Internal PWM line.
    reg  [DT_W-1:0] dtCnt_r;       // Dead-band countdown.
    reg         dtTrue_r;          // Internal dead-time true level.
    reg         dtInv_r;           // Internal dead-time inverse level.
    reg  [7:0]  psCnt_r;           // Prescaler counter.

    // Decoded fields.
    wire [2:0] mode      = ctrl_r[`PDP_CB_MODE_HI:`PDP_CB_MODE_LO];
    wire [1:0] udMode    = ctrl_r[`PDP_CB_UD_HI:`PDP_CB_UD_LO];
    wire [7:0] prescaleOrDeadbandField =
        ctrl_r[`PDP_CB_GEN_HI:`PDP_CB_GEN_LO];
    wire       modeDt    = (mode == `PDP_MODE_DT);
    wire       modePrng  = (mode == `PDP_MODE_PRNG);

    // Software event strobes from a write to the event register.
    wire       swWr = regWr && (regAddr == `PDP_OFS_SWEVT);
    wire [3:0] swEvt = swWr ? regWdata[3:0] : 4'h0;

    // Hardware event detection per trigger line.
    wire [3:0] trIn = {switchIn, killIn, startIn, reloadIn};
    wire [3:0] hwEvt;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : gEvt
            assign hwEvt[gi] = trSel_r[gi] &
                evtDet(edge_r[2*gi+1:2*gi], trIn[gi], trPrev_r[gi]);
        end
    endgenerate

    // Combined events; a start needs software when no hardware start.
    wire evReload = hwEvt[`PDP_EV_RELOAD] | swEvt[`PDP_EV_RELOAD];
    wire evStart  = hwEvt[`PDP_EV_START] | swEvt[`PDP_EV_START];
    wire evKill   = hwEvt[`PDP_EV_KILL] | swEvt[`PDP_EV_KILL];
    // A pass-through switch setting never registers a hardware switch.
    wire evSwitch = swEvt[`PDP_EV_SWITCH] |
        (hwEvt[`PDP_EV_SWITCH] &
         (edge_r[7:6] != `PDP_EDGE_PASS));

    // Kill blocking: latched until terminal count, or level-only.
    wire syncKill = ctrl_r[`PDP_CB_SYNCKILL];
    wire killNow  = syncKill ? (killLatch_r | evKill) : evKill;
    wire stopKill = killNow & ctrl_r[`PDP_CB_STOPKILL];

    // Prescaler: plain PWM only; dead-time and LFSR run every clock.
    wire [7:0] psMask = (8'h01 << prescaleOrDeadbandField[2:0]) - 8'h01;
    wire psTick = modeDt | modePrng |
        ((psCnt_r & psMask) == psMask);

    wire active = enable_r & running_r & psTick & ~stopKill;

    // LFSR feedback for x16+x14+x13+x11+1.
    wire lfsrFb = counter_r[15] ^ counter_r[13] ^
                  counter_r[12] ^ counter_r[10];

    // ==========================================================
    // Counter step logic
    // ==========================================================

    reg  [15:0] cntNxt;            // Next counter value.
    reg         dirNxt;            // Next direction.
    reg         ovEv;              // Count-wrap-high event.
    reg         unEv;              // Count-wrap-low event.
    reg         tcEv;              // Terminal count event.

    // Steps the counter for the selected mode and alignment.
    always @* begin
        cntNxt = counter_r;
        dirNxt = downDir_r;
        ovEv   = 1'b0;
        unEv   = 1'b0;
        tcEv   = 1'b0;
        if (active && modePrng) begin
            cntNxt = {counter_r[14:0], lfsrFb};
            tcEv   = (counter_r == per_r);
        end else if (active) begin
            case (udMode)
                2'h0: begin
                    // Up counting wraps to zero after the period.
                    if (counter_r >= per_r) begin
                        cntNxt = 16'h0000;
                        ovEv   = 1'b1;
                        tcEv   = 1'b1;
                    end else begin
                        cntNxt = counter_r + 16'h0001;
                    end
                end
                2'h1: begin
                    // Down counting reloads the period at zero.
                    if (counter_r == 16'h0000) begin
                        cntNxt = per_r;
                        unEv   = 1'b1;
                        tcEv   = 1'b1;
                    end else begin
                        cntNxt = counter_r - 16'h0001;
                    end
                end
                default: begin
                    // Up/down; code 3 also gives terminal count at top.
                    if (!downDir_r && counter_r >= per_r) begin
                        cntNxt = counter_r - 16'h0001;
                        dirNxt = 1'b1;
                        ovEv   = 1'b1;
                        tcEv   = (udMode == 2'h3);
                    end else if (downDir_r && counter_r == 16'h0000) begin
                        cntNxt = 16'h0001;
                        dirNxt = 1'b0;
                        unEv   = 1'b1;
                        tcEv   = 1'b1;
                    end else if (downDir_r) begin
                        cntNxt = counter_r - 16'h0001;
                    end else begin
                        cntNxt = counter_r + 16'h0001;
                    end
                end
            endcase
        end
    end

    // Match only while running and equal.
    wire ccEv = enable_r & running_r &
                (counter_r == cmp_r);

    // ==========================================================
    // Line generation
    // ==========================================================

    reg lineNxt;                   // Next internal PWM line.

    // Pseudo-random compares low bits; others apply actions.
    always @* begin
        lineNxt = line_r;
        if (modePrng) begin
            lineNxt = ({1'b0, counter_r[14:0]} < cmp_r);
        end else begin
            if (ccEv && active)
                lineNxt = actApply(action_r[1:0], lineNxt);
            if (ovEv)
                lineNxt = actApply(action_r[3:2], lineNxt);
            if (unEv)
                lineNxt = actApply(action_r[5:4], lineNxt);
        end
    end

    wire [DT_W-1:0] dtLen = prescaleOrDeadbandField[DT_W-1:0];

    // ==========================================================
    // Sequential logic
    // ==========================================================

    // Registers, counter, switching, kill and dead-band insertion.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            enable_r    <= 1'b0;
            ctrl_r      <= `PDP_RST_CTRL;
            counter_r   <= 16'h0000;
            cmp_r       <= 16'h0000;
            cmpBuf_r    <= 16'h0000;
            per_r       <= `PDP_RST_PER;
            perBuf_r    <= `PDP_RST_PER;
            trSel_r     <= 4'h0;
            edge_r      <= 8'h00;
            action_r    <= `PDP_RST_ACTION;
            trPrev_r    <= 4'h0;
            running_r   <= 1'b0;
            downDir_r   <= 1'b0;
            swPend_r    <= 1'b0;
            killLatch_r <= 1'b0;
            line_r      <= 1'b0;
            dtCnt_r     <= {DT_W{1'b0}};
            dtTrue_r    <= 1'b0;
            dtInv_r     <= 1'b0;
            psCnt_r     <= 8'h00;
        end else begin
            trPrev_r  <= trIn;
            psCnt_r   <= psCnt_r + 8'h01;
            counter_r <= cntNxt;
            downDir_r <= dirNxt;
            line_r    <= lineNxt;
            // Start waits for an event; reload also starts.
            if (!enable_r) begin
                running_r <= 1'b0;
            end else if (evStart || evReload) begin
                running_r <= 1'b1;
            end else if (tcEv && ctrl_r[`PDP_CB_ONESHOT]) begin
                running_r <= 1'b0;
            end
            // Plain reload initialises the counter; LFSR keeps it.
            if (evReload && enable_r && !modePrng) begin
                counter_r <= (udMode == 2'h1) ? per_r : 16'h0000;
                downDir_r <= 1'b0;
            end
            // Switch is remembered until terminal count; set wins.
            swPend_r <= evSwitch | (swPend_r & ~tcEv);
            if (tcEv && swPend_r) begin
                if (ctrl_r[`PDP_CB_CMPSWAP]) begin
                    cmp_r    <= cmpBuf_r;
                    cmpBuf_r <= cmp_r;
                end
                if (ctrl_r[`PDP_CB_PERSWAP]) begin
                    per_r    <= perBuf_r;
                    perBuf_r <= per_r;
                end
            end
            // Sync kill holds to terminal count; new kill wins.
            killLatch_r <= syncKill &
                (evKill | (killLatch_r & ~tcEv));
            // Dead band: edges zero both and reload the countdown; a zero length passes the edge straight through.
            if (lineNxt != line_r) begin
                if (dtLen == {DT_W{1'b0}}) begin
                    dtTrue_r <= lineNxt;
                    dtInv_r  <= ~lineNxt;
                    dtCnt_r  <= {DT_W{1'b0}};
                end else begin
                    dtTrue_r <= 1'b0;
                    dtInv_r  <= 1'b0;
                    dtCnt_r  <= dtLen;
                end
            end else if (dtCnt_r != {DT_W{1'b0}}) begin
                dtCnt_r <= dtCnt_r - {{(DT_W-1){1'b0}}, 1'b1};
                if (dtCnt_r == {{(DT_W-1){1'b0}}, 1'b1}) begin
                    dtTrue_r <= line_r;
                    dtInv_r  <= ~line_r;
                end
            end
            // Register writes; software write wins over a swap.
            if (regWr) begin
                case (regAddr)
                    `PDP_OFS_ENABLE:  enable_r  <= regWdata[0];
                    `PDP_OFS_CTRL:    ctrl_r    <= regWdata;
                    `PDP_OFS_COUNTER: counter_r <= regWdata[15:0];
                    `PDP_OFS_CMP:     cmp_r     <= regWdata[15:0];
                    `PDP_OFS_CMPBUF:  cmpBuf_r  <= regWdata[15:0];
                    `PDP_OFS_PER:     per_r     <= regWdata[15:0];
                    `PDP_OFS_PERBUF:  perBuf_r  <= regWdata[15:0];
                    `PDP_OFS_TRSEL:   trSel_r   <= regWdata[3:0];
                    `PDP_OFS_EDGE:    edge_r    <= regWdata[7:0];
                    `PDP_OFS_ACTION:  action_r  <= regWdata[5:0];
                    default: ;
                endcase
            end
        end
    end

    // ==========================================================
    // Outputs and read port
    // ==========================================================

    // Registered outputs; kill blocks every output line.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            lineOut              <= 1'b0;
            lineOutInv           <= 1'b0;
            delayedOutputTrue    <= 1'b0;
            delayedOutputInverse <= 1'b0;
            terminalCount        <= 1'b0;
            compareMatch         <= 1'b0;
            irqReq               <= 1'b0;
            regRdata             <= 32'h0000_0000;
        end else begin
            lineOut              <= line_r & ~killNow;
            lineOutInv           <= ~line_r & ~killNow;
            delayedOutputTrue    <= dtTrue_r & ~killNow;
            delayedOutputInverse <= dtInv_r & ~killNow;
            terminalCount        <= tcEv;
            compareMatch         <= ccEv;
            irqReq <= (tcEv & ctrl_r[`PDP_CB_IRQTC]) |
                      (ccEv & ctrl_r[`PDP_CB_IRQCC]);
            // No wrap events exist in LFSR mode by construction.
            regRdata <= 32'h0000_0000;
            if (regRd) begin
                case (regAddr)
                    `PDP_OFS_ENABLE:  regRdata <= {31'h0, enable_r};
                    `PDP_OFS_CTRL:    regRdata <= ctrl_r;
                    `PDP_OFS_STATUS:  regRdata <= {dtCnt_r, 20'h0,
                        swPend_r, killLatch_r, downDir_r, running_r};
                    `PDP_OFS_COUNTER: regRdata <= {16'h0, counter_r};
                    `PDP_OFS_CMP:     regRdata <= {16'h0, cmp_r};
                    `PDP_OFS_CMPBUF:  regRdata <= {16'h0, cmpBuf_r};
                    `PDP_OFS_PER:     regRdata <= {16'h0, per_r};
                    `PDP_OFS_PERBUF:  regRdata <= {16'h0, perBuf_r};
                    `PDP_OFS_TRSEL:   regRdata <= {28'h0, trSel_r};
                    `PDP_OFS_EDGE:    regRdata <= {24'h0, edge_r};
                    `PDP_OFS_ACTION:  regRdata <= {26'h0, action_r};
                    default:          regRdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // pdp_channel

// [verif/pdp_far_side.sv]
// Far-side model: trigger sources and the two power switches.
// Assumes the bench hands it a trigger command at each clock edge.
`timescale 1ns/100ps
module pdp_far_side (
    input  wire       ref_clk,
    input  wire       sys_rst,
    input  wire [3:0] trigCmd,
    input  wire       delayedOutputTrue,
    input  wire       delayedOutputInverse,
    output reg        reloadIn = 1'b0,
    output reg        startIn = 1'b0,
    output reg        killIn = 1'b0,
    output reg        switchIn = 1'b0,
    output reg  [7:0] overlapCnt = 8'h00
);
    // ==========
    // Trigger lines change just after an edge and hold a full cycle.
    // Counts cycles with both switches closed, a supply short.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            {switchIn, killIn, startIn, reloadIn} <= 4'h0;
            overlapCnt <= 8'h00;
        end else begin
            {switchIn, killIn, startIn, reloadIn} <= trigCmd;
            if (delayedOutputTrue && delayedOutputInverse) begin
                overlapCnt <= overlapCnt + 8'h01;
            end
        end
    end
endmodule // pdp_far_side

// [verif/pdp_channel_props.sv]
// Checker for the dead-time and pseudo-random channel.
// Assumes it is bound to the channel's ports.
`timescale 1ns/100ps
module pdp_props #(
    parameter DT_W = 8
) (
    input wire        ref_clk,
    input wire        sys_rst,
    input wire [7:0]  regAddr,
    input wire [31:0] regWdata,
    input wire        regWr,
    input wire        reloadIn,
    input wire        startIn,
    input wire        lineOut,
    input wire        lineOutInv,
    input wire        delayedOutputTrue,
    input wire        delayedOutputInverse,
    input wire        terminalCount,
    input wire        compareMatch,
    input wire        irqReq
);
    // ==========
    reg  [2:0]    mode_r;  // Mode as last written.
    reg  [7:0]    band_r;  // Dead-band length as last written.
    reg           go_r;    // A start or reload has been seen.
    reg  [3:0]    age_r;   // Cycles since the last control write.
    reg  [DT_W:0] hi_r;    // Cycles the line has stood high.
    reg  [DT_W:0] lo_r;    // Cycles the line has stood low.
    wire dtT = delayedOutputTrue;
    wire dtI = delayedOutputInverse;
    wire dt  = mode_r == 3'h5 && age_r > 4'h3;
    wire swGo = regWr && regAddr == 8'h08 && |regWdata[1:0];
    // Shadows the control fields and the run-lengths of the line.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            hi_r <= '0;
            lo_r <= '0;
            mode_r <= 3'h4;
            band_r <= 8'h00;
            go_r <= 1'b0;
            age_r <= 4'h0;
        end else begin
            hi_r <= lineOut ? hi_r + {{DT_W{1'b0}}, ~&hi_r} : '0;
            lo_r <= lineOut ? '0 : lo_r + {{DT_W{1'b0}}, ~&lo_r};
            if (regWr && regAddr == 8'h04) begin
                mode_r <= regWdata[26:24];
                band_r <= regWdata[15:8];
                age_r <= 4'h0;
            end else if (age_r != 4'hF) begin
                age_r <= age_r + 4'h1;
            end
            if (startIn || reloadIn || swGo) begin
                go_r <= 1'b1;
            end
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    property p_apart; !(dtT && dtI); endproperty
    a_apart: assert property (p_apart)
        else $error("Both dead-time outputs high.");
    property p_compl; !(lineOut && lineOutInv); endproperty
    a_compl: assert property (p_compl)
        else $error("Line and complement both high.");
    property p_rise; dt && band_r > 8'h01 && $rose(lineOut) |=> !dtT && !dtI;
    endproperty
    a_rise: assert property (p_rise)
        else $error("Dead-time outputs not zeroed.");
    property p_tw; dt && band_r != 0 && $rose(dtT) |-> hi_r >= band_r;
    endproperty
    a_tw: assert property (p_tw)
        else $error("True output rose early.");
    property p_iw; dt && band_r != 0 && $rose(dtI) |-> lo_r >= band_r;
    endproperty
    a_iw: assert property (p_iw)
        else $error("Inverse output rose early.");
    property p_follow; dt && band_r == 0 |-> dtT == lineOut; endproperty
    a_follow: assert property (p_follow)
        else $error("True output does not follow the line.");
    property p_idle; !go_r |-> !terminalCount && !compareMatch; endproperty
    a_idle: assert property (p_idle)
        else $error("Counter events before any start.");
    property p_irq; irqReq |-> terminalCount || compareMatch
        || $past(terminalCount) || $past(compareMatch); endproperty
    a_irq: assert property (p_irq)
        else $error("Interrupt without a cause.");
endmodule // pdp_props
bind pdp_channel pdp_props #(.DT_W(DT_W)) i_pdp_props (.*);

// [verif/pdp_channel_tb.sv]
// Self-checking bench for the channel.
// Assumes the channel, checker and far-side model.
`timescale 1ns/100ps
module pdp_channel_tb;
    // ==========
    reg         ref_clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg  [7:0]  regAddr = 8'h00;
    reg  [31:0] regWdata = 32'h0;
    reg         regWr = 1'b0;
    reg         regRd = 1'b0;
    reg  [3:0]  trigCmd = 4'h0;  // Far-side triggers.
    reg         irqSeen = 1'b0;  // Interrupt seen.
    reg  [31:0] v, w;            // Reads, expectations.
    wire [31:0] regRdata;
    wire        reloadIn, startIn, killIn, switchIn, lineOut, lineOutInv;
    wire        delayedOutputTrue, delayedOutputInverse;
    wire        terminalCount, compareMatch, irqReq;
    wire [7:0]  overlapCnt;
    integer     fails = 0;
    integer     comparisons = 0;
    integer     k, hiN, loN, lineN;
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (irqReq === 1'b1) irqSeen <= 1'b1;
    pdp_channel i_pdp_channel (.*);
    pdp_far_side i_pdp_far_side (.*);
    // ==========
    // One step of the sixteen-bit shift sequence.
    function [31:0] nx(input [31:0] c);
        nx = {16'h0, c[14:0], c[15] ^ c[13] ^ c[12] ^ c[10]};
    endfunction
    task check(input string what, input [31:0] seen, input [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task close_out;
        if (fails == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task rst;
        sys_rst <= 1'b1;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task rd(input [7:0] a);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 v = regRdata;
    endtask
    // Two counter reads one step apart.
    task rd2;
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= 8'h10;
        @(posedge ref_clk);
        #1 v = regRdata;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 w = regRdata;
    endtask
    task waitTc;
        for (k = 0; k < 70000 && terminalCount !== 1'b1; k = k + 1) begin
            @(posedge ref_clk);
            #1;
        end
    endtask
    // ==========
    task t_regs;
        rd(8'h04);
        check("control reset", v, 32'h04000000);
        rd(8'h40);
        check("unmapped read", v, 32'h0);
    endtask
    // Reload start, one step per clock, full sequence length.
    task t_prng;
        rst;
        w = 32'hACE1;
        wr(8'h10, w);
        repeat (40) w = nx(w);
        wr(8'h1C, w);
        wr(8'h14, 32'h8000);
        wr(8'h04, 32'h06000020);
        wr(8'h00, 32'h1);
        wr(8'h08, 32'h1);
        rd2;
        check("lfsr step", w, nx(v));
        check("line full compare", lineOut, 1);
        w = 32'hACE1;
        for (k = 0; k < 8 && w !== v; k = k + 1) w = nx(w);
        check("reload keeps count", v, w);
        waitTc;
        #5;
        waitTc;
        check("sequence length", k + 1, 65535);
        check("tc interrupt", irqSeen, 1);
    endtask
    // Single run with a hardware switch pending until terminal count.
    task t_shot;
        rst;
        w = 32'h1;
        wr(8'h10, w);
        repeat (30) w = nx(w);
        wr(8'h1C, w);
        wr(8'h18, 32'h8000);
        wr(8'h24, 32'h8);
        wr(8'h04, 32'h06000005);
        wr(8'h00, 32'h1);
        wr(8'h08, 32'h2);
        trigCmd <= 4'h8;
        @(posedge ref_clk);
        trigCmd <= 4'h0;
        check("line zero compare", lineOut, 0);
        waitTc;
        check("tc reached", k < 70000, 1);
        repeat (4) @(posedge ref_clk);
        rd2;
        check("stopped", w, v);
        rd(8'h14);
        check("compare swapped", v, 32'h8000);
    endtask
    // Period-20 line through the dead band, then a kill.
    task t_dt(input [7:0] n, input [1:0] expOn);
        rst;
        wr(8'h1C, 32'h13);
        wr(8'h14, 32'h0A);
        wr(8'h2C, 32'h31);
        wr(8'h28, 32'h30);
        wr(8'h24, 32'h4);
        wr(8'h04, {8'h05, 8'h00, n, 8'h00});
        wr(8'h00, 32'h1);
        wr(8'h08, 32'h2);
        hiN = 0;
        loN = 0;
        lineN = 0;
        repeat (100) begin
            @(posedge ref_clk);
            hiN = hiN + (delayedOutputTrue === 1'b1);
            loN = loN + (delayedOutputInverse === 1'b1);
            lineN = lineN + (lineOut === 1'b1);
        end
        check("dead-time sides", {hiN != 0, loN != 0}, expOn);
        check("unprescaled", lineN > 30, 1);
        check("no overlap", overlapCnt, 0);
        trigCmd <= 4'h4;
        repeat (4) @(posedge ref_clk);
        check("kill", {lineOut, lineOutInv, delayedOutputTrue,
            delayedOutputInverse}, 0);
        trigCmd <= 4'h0;
    endtask
    initial begin
        rst;
        t_regs;
        t_prng;
        t_shot;
        t_dt(8'h04, 2'b11);
        t_dt(8'h0C, 2'b00);
        t_dt(8'h00, 2'b11);
        close_out;
    end
    initial begin
        repeat (90000) @(posedge ref_clk);
        fails = fails + 1;
        close_out;
    end
endmodule // pdp_channel_tb
